// ===== cdt_timer.v
/*
 * Countdown timer with periodic reload, interrupt pending flag,
 * pre-divider, two-bit prescale, width select and a separate
 * free-running up counter, behind a classic Wishbone slave.
 * Assumes a single clock; dbg_halt_i is asynchronous to it.
 */
`timescale 1ns/1ns
`include "cdt_timer_map.vh"

module cdt_timer #(
    // identification word read back from the clear register (arbitrary)
    parameter [31:0] ID_WORD = 32'h5A5A0001
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // core debug state
    input wire dbg_halt_i,
    // interrupt
    output reg irq_o
);

    // ***************************************
    // helper functions
    // ***************************************

    // apply wishbone byte enables to a 32-bit register
    function [31:0] byte_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] sel;
        integer i;
        begin
            byte_merge = old_val;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (sel[i])
                begin
                    byte_merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // terminal count of the prescale stage for a selection
    function [7:0] presc_tc;
        input [1:0] sel;
        begin
            case (sel)
                `CDT_PRESC_DIV16: presc_tc = `CDT_PRESC_TC16;
                `CDT_PRESC_DIV256: presc_tc = `CDT_PRESC_TC256;
                // 00 and 11 both pass every tick
                default: presc_tc = 8'h00;
            endcase
        end
    endfunction

    // ***************************************
    // declarations
    // ***************************************
    reg dbg_meta_r; // first synchroniser stage, read only by stage two
    reg dbg_sync_r; // debug halt level in the clock domain
    reg [31:0] load_r; // load value shared by both load registers
    reg [31:0] count_r; // live down count
    reg [7:0] free_presc_r; // free counter divide field
    reg free_en_r; // free counter enable
    reg halt_dbg_r; // stop counters during debug halt
    reg timer_en_r; // down counter enable
    reg irq_en_r; // interrupt enable
    reg [1:0] presc_sel_r; // down counter prescale select
    reg wide_r; // 1 selects 32-bit counting
    reg pend_r; // sticky interrupt pending flag
    reg [9:0] tick_predivider_r; // pre-divider value
    reg [9:0] pdiv_cnt_r; // pre-divider counter
    reg [7:0] presc_cnt_r; // prescale counter
    reg [7:0] fdiv_cnt_r; // free counter divider
    reg [31:0] free_cnt_r; // free-running count
    wire halted; // counters frozen by debug
    wire bus_req; // a new bus request this cycle
    wire wr_req; // a write taken this cycle
    wire pdiv_tick; // pre-divided tick
    wire cnt_tick; // prescaled decrement strobe
    wire at_zero; // counter sits at zero in current width
    wire zero_hit; // reload event
    wire free_tick; // free counter step
    wire [31:0] ctrl_word; // control register image
    wire [31:0] tick_predivider_merged; // pre-divider write image before trimming
    reg [31:0] rd_nxt; // read data next value

    // ***************************************
    // debug halt synchroniser
    // ***************************************

    // two flops before any logic reads the pin
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dbg_meta_r <= 1'b0;
            dbg_sync_r <= 1'b0;
        end
        else
        begin
            dbg_meta_r <= dbg_halt_i;
            dbg_sync_r <= dbg_meta_r;
        end
    end

    // RULE8 halt gating
    // halt only when software asked for it and the core is halted
    assign halted = halt_dbg_r & dbg_sync_r;

    // ***************************************
    // bus decode
    // ***************************************

    // ack is given one cycle after the request and dropped after
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_req = bus_req & wb_we_i;

    // control image, reserved bits read zero
    assign ctrl_word = {8'h00, free_presc_r, 6'h00, free_en_r,
                        halt_dbg_r, timer_en_r, 1'b0, irq_en_r,
                        1'b0, presc_sel_r, wide_r, 1'b0};

    // only the low ten bits of a pre-divider write are kept
    assign tick_predivider_merged = byte_merge({22'h000000, tick_predivider_r}, wb_dat_i, wb_sel_i);

    // ***************************************
    // tick generation
    // ***************************************

    // RULE14 pre-divider tick
    // one tick every tick_predivider+1 clocks
    assign pdiv_tick = (pdiv_cnt_r >= tick_predivider_r);

    // RULE11 prescale stage
    // RULE5 combined rate
    assign cnt_tick = pdiv_tick &
                      (presc_cnt_r >= presc_tc(presc_sel_r));

    // RULE18 width-aware zero test
    assign at_zero = wide_r ? (count_r == 32'h00000000)
                            : (count_r[15:0] == 16'h0000);

    // RULE4 reload on a tick at zero
    assign zero_hit = timer_en_r & ~halted & cnt_tick & at_zero;

    // RULE6 free divider
    assign free_tick = free_en_r & ~halted &
                       (fdiv_cnt_r >= free_presc_r);

    // ***************************************
    // divider counters
    // ***************************************

    // pre-divider and prescale run only while the timer counts;
    // a register change that shrinks a divide point is caught by
    // the >= compare, so a counter never runs away past it
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pdiv_cnt_r <= 10'h000;
            presc_cnt_r <= 8'h00;
        end
        else if (timer_en_r & ~halted)
        begin
            if (pdiv_tick)
            begin
                pdiv_cnt_r <= 10'h000;
                // prescale steps once per pre-divided tick
                if (cnt_tick)
                begin
                    presc_cnt_r <= 8'h00;
                end
                else
                begin
                    presc_cnt_r <= presc_cnt_r + 8'h01;
                end
            end
            else
            begin
                pdiv_cnt_r <= pdiv_cnt_r + 10'h001;
            end
        end
        else if (~timer_en_r)
        begin
            // restart the divide chain cleanly when stopped
            pdiv_cnt_r <= 10'h000;
            presc_cnt_r <= 8'h00;
        end
    end

    // ***************************************
    // down counter
    // ***************************************

    // RULE1 continuous reload is the only mode
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_r <= `CDT_RST_LOAD;
        end
        // RULE2 immediate copy on load write
        else if (wr_req && wb_adr_i == `CDT_OFS_LOAD)
        begin
            count_r <= byte_merge(load_r, wb_dat_i, wb_sel_i);
        end
        // RULE4 reload at zero
        else if (zero_hit)
        begin
            count_r <= load_r;
        end
        // RULE9 enable gate
        // RULE3 decrement per tick
        else if (timer_en_r & ~halted & cnt_tick)
        begin
            if (wide_r)
            begin
                count_r <= count_r - 32'h00000001;
            end
            else
            begin
                // RULE18 low half only counts in 16-bit mode
                count_r[15:0] <= count_r[15:0] - 16'h0001;
            end
        end
    end

    // ***************************************
    // free-running counter
    // ***************************************

    // RULE13 separate counter
    // RULE17 counts and rolls over, no software reset
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fdiv_cnt_r <= 8'h00;
            free_cnt_r <= 32'h00000000;
        end
        // RULE7 enable gate
        else if (free_en_r & ~halted)
        begin
            if (free_tick)
            begin
                fdiv_cnt_r <= 8'h00;
                free_cnt_r <= free_cnt_r + 32'h00000001;
            end
            else
            begin
                fdiv_cnt_r <= fdiv_cnt_r + 8'h01;
            end
        end
    end

    // ***************************************
    // software registers
    // ***************************************

    // load, control and pre-divider writes honour byte enables
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            load_r <= `CDT_RST_LOAD;
            tick_predivider_r <= `CDT_RST_TICK_PREDIVIDER;
            free_presc_r <= `CDT_RST_FREE_PRESC;
            free_en_r <= 1'b0;
            halt_dbg_r <= 1'b0;
            timer_en_r <= 1'b0;
            irq_en_r <= `CDT_RST_IRQ_EN;
            presc_sel_r <= 2'h0;
            wide_r <= 1'b0;
        end
        else if (wr_req)
        begin
            case (wb_adr_i)
                // RULE19 deferred load shares the value register
                `CDT_OFS_LOAD, `CDT_OFS_DEFER_LOAD:
                begin
                    load_r <= byte_merge(load_r, wb_dat_i, wb_sel_i);
                end
                `CDT_OFS_CTRL:
                begin
                    if (wb_sel_i[2])
                    begin
                        // RULE6 free counter divide field
                        free_presc_r <= wb_dat_i[`CDT_FREE_PRESC_HI:`CDT_FREE_PRESC_LO];
                    end
                    if (wb_sel_i[1])
                    begin
                        // RULE7 free enable
                        free_en_r <= wb_dat_i[`CDT_FREE_EN_BIT];
                        // RULE8 debug halt select
                        halt_dbg_r <= wb_dat_i[`CDT_HALT_DBG_BIT];
                    end
                    if (wb_sel_i[0])
                    begin
                        // RULE9 timer enable
                        timer_en_r <= wb_dat_i[`CDT_TIMER_EN_BIT];
                        // RULE10 interrupt enable
                        irq_en_r <= wb_dat_i[`CDT_IRQ_EN_BIT];
                        // RULE11 prescale select
                        presc_sel_r <= wb_dat_i[`CDT_PRESC_HI:`CDT_PRESC_LO];
                        // RULE12 width select
                        wide_r <= wb_dat_i[`CDT_WIDTH_SEL_BIT];
                    end
                end
                `CDT_OFS_TICK_PREDIVIDER:
                begin
                    tick_predivider_r <= tick_predivider_merged[9:0];
                end
                default:
                begin
                    // read-only and unmapped writes are dropped
                end
            endcase
        end
    end

    // ***************************************
    // interrupt pending flag
    // ***************************************

    // a zero reload in the same cycle as a clear keeps the flag set,
    // so no period is ever lost to a racing acknowledge
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_r <= 1'b0;
        end
        // RULE4 set pending
        else if (zero_hit)
        begin
            pend_r <= 1'b1;
        end
        // RULE16 write one to clear
        else if (wr_req && wb_adr_i == `CDT_OFS_IRQ_CLEAR &&
                 wb_sel_i[0] && wb_dat_i[`CDT_IRQ_BIT])
        begin
            pend_r <= 1'b0;
        end
    end

    // RULE15 line is pending AND enable
    // registered, so it follows the flag by one clock
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= pend_r & irq_en_r;
        end
    end

    // ***************************************
    // read mux
    // ***************************************

    // RULE18 count reads return the live counter
    always @*
    begin
        rd_nxt = 32'h00000000;
        case (wb_adr_i)
            `CDT_OFS_LOAD: rd_nxt = load_r;
            `CDT_OFS_DEFER_LOAD: rd_nxt = load_r;
            `CDT_OFS_COUNT: rd_nxt = count_r;
            `CDT_OFS_CTRL: rd_nxt = ctrl_word;
            `CDT_OFS_IRQ_CLEAR: rd_nxt = ID_WORD;
            `CDT_OFS_IRQ_RAW: rd_nxt = {31'h00000000, pend_r};
            `CDT_OFS_IRQ_MASKED: rd_nxt = {31'h00000000, pend_r & irq_en_r};
            `CDT_OFS_TICK_PREDIVIDER: rd_nxt = {22'h000000, tick_predivider_r};
            `CDT_OFS_FREE_COUNT: rd_nxt = free_cnt_r;
            // unmapped addresses answer with zero
            default: rd_nxt = 32'h00000000;
        endcase
    end

    // ***************************************
    // bus answer
    // ***************************************

    // every address is acked, one wait-free cycle after the request
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req & ~wb_we_i)
            begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

endmodule // cdt_timer

// ===== cdt_timer_map.vh
/*
 * Register offsets, field positions and reset values of the
 * countdown timer with free-running counter.
 * Assumes a byte-addressed bus with one 32-bit word per register.
 */
// How it works
// RULE1 - one down timer, periodic reload only
// RULE2 - load write copies value into count
// RULE3 - enabled count decrements per divided tick
// RULE4 - at zero reload and set pending
// RULE5 - pre-divider and prescale set count rate
// RULE6 - bits 23:16 divide free counter by n+1
// RULE7 - bit 9 enables free counter, reset 0
// RULE8 - bit 8 halts counters in debug halt
// RULE9 - bit 7 enables down counter, reset 0
// RULE10 - bit 5 enables interrupt, resets to 1
// RULE11 - bits 3:2 divide by 1,16,256,1
// RULE12 - bit 1 selects 16 or 32 bit
// RULE13 - separate readable 32-bit free counter
// RULE14 - tick is clock over pre-divider plus one
// RULE15 - interrupt is pending AND enable
// RULE16 - writing 1 to clear bit 0 clears pending
// RULE17 - free counter increments, rolls over, no reset
// RULE18 - 16-bit mode counts low half, live reads
// RULE19 - deferred load waits for next zero reload
`ifndef CDT_TIMER_MAP_VH
`define CDT_TIMER_MAP_VH

// ***************************************
// register byte offsets
// ***************************************
`define CDT_OFS_LOAD 12'h400
`define CDT_OFS_COUNT 12'h404
`define CDT_OFS_CTRL 12'h408
`define CDT_OFS_IRQ_CLEAR 12'h40C
`define CDT_OFS_IRQ_RAW 12'h410
`define CDT_OFS_IRQ_MASKED 12'h414
`define CDT_OFS_DEFER_LOAD 12'h418
`define CDT_OFS_TICK_PREDIVIDER 12'h41C
`define CDT_OFS_FREE_COUNT 12'h420

// ***************************************
// control field positions
// ***************************************
`define CDT_FREE_PRESC_HI 23
`define CDT_FREE_PRESC_LO 16
`define CDT_FREE_EN_BIT 9
`define CDT_HALT_DBG_BIT 8
`define CDT_TIMER_EN_BIT 7
`define CDT_IRQ_EN_BIT 5
`define CDT_PRESC_HI 3
`define CDT_PRESC_LO 2
`define CDT_WIDTH_SEL_BIT 1
`define CDT_IRQ_BIT 0

// ***************************************
// reset values
// ***************************************
`define CDT_RST_FREE_PRESC 8'h3E
`define CDT_RST_IRQ_EN 1'h1
`define CDT_RST_TICK_PREDIVIDER 10'h07D
`define CDT_RST_LOAD 32'h00000000

// ***************************************
// prescale selections and terminal counts
// ***************************************
`define CDT_PRESC_DIV16 2'h1
`define CDT_PRESC_DIV256 2'h2
`define CDT_PRESC_TC16 8'h0F
`define CDT_PRESC_TC256 8'hFF

`endif

// ===== cdt_timer_monitor.sv
/* checker of the countdown timer bus and interrupt ports
   assumes one clock domain with a synchronous active-high reset */
`timescale 1ns/1ns
`include "cdt_timer_map.vh"
module cdt_timer_monitor #(
    parameter [31:0] ID_WORD = 32'h5A5A0001
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // debug and interrupt
    input wire dbg_halt_i,
    input wire irq_o
);
    // ****
    // request decode
    // ****
    // a request counts only while no ack stands, else it is a repeat
    wire rd_take = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    wire wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ****
    // assertions
    // ****
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood two cycles");
    a_ack_on_request: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_only_request: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_id_word_read: assert property (rd_take && wb_adr_i == `CDT_OFS_IRQ_CLEAR |=> wb_dat_o == ID_WORD)
        else $error("clear register read wrong word");
    a_hole_reads_zero: assert property (rd_take && (wb_adr_i < `CDT_OFS_LOAD || wb_adr_i > `CDT_OFS_FREE_COUNT)
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_read_data_holds: assert property (!rd_take |=> $stable(wb_dat_o))
        else $error("read data moved without a read");
    a_masked_is_irq: assert property (
        rd_take && wb_adr_i == `CDT_OFS_IRQ_MASKED |=> wb_dat_o == {31'h0, irq_o})
        else $error("masked status differs from irq");
    a_raw_covers_irq: assert property (
        rd_take && wb_adr_i == `CDT_OFS_IRQ_RAW |=> wb_dat_o[31:1] == 31'h0 && (wb_dat_o[0] || !irq_o))
        else $error("irq high with raw flag clear");
    a_clear_drops_irq: assert property (
        wr_take && wb_adr_i == `CDT_OFS_IRQ_CLEAR && wb_sel_i[0] && wb_dat_i[0] |=> ##1 !irq_o)
        else $error("irq stayed after clear");
endmodule // cdt_timer_monitor

bind cdt_timer cdt_timer_monitor #(.ID_WORD(ID_WORD)) u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dbg_halt_i(dbg_halt_i), .irq_o(irq_o)
);

// ===== cdt_timer_tb_top.sv
/* self-checking bench of the countdown timer
   drives bus and debug halt itself; read answers checked from a queue */
`timescale 1ns/1ns
module cdt_timer_tb_top;
    // arbitrary identification word
    localparam [31:0] ID = 32'h3C3C0005;
    localparam [31:0] ALL = 32'hFFFFFFFF;
    // ****
    // signals
    // ****
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic dbg = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    wire [31:0] rdat;
    wire ack;
    wire irq;
    logic [63:0] exp_q[$]; // {mask, value} of each read in flight
    logic [63:0] e;
    logic [31:0] r;
    int err_count = 0;
    int samples_checked = 0;
    int tick_n = 0;
    int fac[4] = '{1, 16, 256, 1};
    always #2 clk_i = ~clk_i;
    cdt_timer #(.ID_WORD(ID)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .dbg_halt_i(dbg), .irq_o(irq));
    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one classic cycle: hold until ack sampled, then idle a cycle
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        exp_q.push_back({m, v});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wait_irq(input int lim, output int n);
        n = 0;
        while (irq !== 1'b1 && n < lim)
        begin
            @(posedge clk_i);
            n++;
        end
    endtask
    // second interrupt gap gives the steady reload period
    task automatic run(input logic [31:0] ctrl, input int per);
        int n;
        wr(12'h408, ctrl);
        wait_irq(2 * per + 20, n);
        wr(12'h40C, 32'h1);
        wait_irq(per + 20, n);
        chk(32'(n >= per - 6 && n <= per), 32'h1);
        wr(12'h408, 32'h20);
        wr(12'h40C, 32'h1);
    endtask
    // ****
    // answer watcher and timeout
    // ****
    always @(posedge clk_i)
    begin
        tick_n++;
        if (tick_n == 20000)
        begin
            err_count++;
            end_of_test();
        end
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            chk(rdat & e[63:32], e[31:0]);
        end
    end
    // ****
    // main sequence
    // ****
    initial
    begin
        r = $urandom(27570);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(12'h400, ALL, 32'h0);
        rd(12'h404, ALL, 32'h0);
        rd(12'h408, 32'h00FF03AE, 32'h003E0020);
        rd(12'h40C, ALL, ID);
        rd(12'h414, ALL, 32'h0);
        rd(12'h41C, ALL, 32'h7D);
        rd(12'h420, ALL, 32'h0);
        rd(12'h424, ALL, 32'h0);
        $display("test reset done");
        r = $urandom();
        wr(12'h400, r);
        rd(12'h404, ALL, r);
        wr(12'h404, ~r);
        rd(12'h404, ALL, r);
        wr(12'h418, ~r);
        rd(12'h404, ALL, r);
        rd(12'h400, ALL, ~r);
        r = $urandom();
        wr(12'h41C, r);
        rd(12'h41C, 32'h3FF, r & 32'h3FF);
        $display("test registers done");
        wr(12'h408, 32'h00030220);
        repeat (405) @(posedge clk_i);
        wr(12'h408, 32'h00030020);
        rd(12'h420, 32'hFFFFFFFC, 32'h64);
        wr(12'h408, 32'hFFFFFF7F);
        rd(12'h408, 32'h00FF03AE, 32'h00FF032E);
        $display("test control done");
        wr(12'h41C, 32'h0);
        wr(12'h400, 32'h3);
        wr(12'h408, 32'h80);
        repeat (40) @(posedge clk_i);
        chk(irq, 32'h0);
        wr(12'h408, 32'h0);
        rd(12'h410, ALL, 32'h1);
        rd(12'h414, ALL, 32'h0);
        wr(12'h408, 32'h20);
        @(posedge clk_i);
        chk(irq, 32'h1);
        wr(12'h40C, 32'h1);
        rd(12'h410, ALL, 32'h0);
        chk(irq, 32'h0);
        $display("test interrupt done");
        wr(12'h400, 32'h00010000);
        wr(12'h408, 32'hA2);
        repeat (30) @(posedge clk_i);
        chk(irq, 32'h0);
        wr(12'h408, 32'h22);
        rd(12'h404, 32'hFFFF0000, 32'h0);
        wr(12'h400, 32'h00010000);
        wr(12'h408, 32'hA0);
        repeat (10) @(posedge clk_i);
        chk(irq, 32'h1);
        wr(12'h408, 32'h20);
        rd(12'h404, 32'hFFFF0000, 32'h00010000);
        wr(12'h40C, 32'h1);
        $display("test width done");
        // debug halt is ignored while the halt bit is clear
        dbg <= 1'b1;
        wr(12'h41C, 32'h1);
        wr(12'h400, 32'h00010003);
        for (int i = 0; i < 4; i++)
            run(32'hA0 | 32'(i << 2), 8 * fac[i]);
        $display("test prescale done");
        wr(12'h408, 32'h1A0);
        repeat (40) @(posedge clk_i);
        chk(irq, 32'h0);
        dbg <= 1'b0;
        repeat (40) @(posedge clk_i);
        chk(irq, 32'h1);
        wr(12'h408, 32'h20);
        wr(12'h40C, 32'h1);
        $display("test halt done");
        end_of_test();
    end
endmodule // cdt_timer_tb_top
